// *** rtl/ddrsg_consts.svh ***
// Purpose: Timing constants for the DDR4 low-power and calibration guard.
// Assumes: Controller clock of 200 MHz (5 ns period).
// Notes: Times in ps are converted to cycles in the guard module.
`ifndef DDRSG_CONSTS_SVH
`define DDRSG_CONSTS_SVH
`define DDRSG_CLK_PS 5000
`define DDRSG_ZQINIT_NCK 1024
`define DDRSG_ZQOPER_NCK 512
`define DDRSG_ZQCS_NCK 128
`define DDRSG_CPDED_NCK 4
`define DDRSG_XPR_NCK 5
`define DDRSG_CKSRE_NCK 5
`define DDRSG_CKSRE_PS 10000
`define DDRSG_CKSRX_NCK 5
`define DDRSG_CKSRX_PS 10000
`define DDRSG_CKE_NCK 3
`define DDRSG_CKE_PS 5000
`define DDRSG_RFC_EXTRA_PS 10000
`define DDRSG_CKESR_EXTRA_NCK 1
`define DDRSG_CNT_W 16
`endif

// *** rtl/ddrsg_pkg.sv ***
// Purpose: Types shared by the guard and its counter.
// Assumes: Nothing beyond the constants header.
// Notes: Commands are those the guard spaces.
package ddrsg_pkg;
  typedef enum logic [3:0] {
    DDRSG_CMD_NOP = 4'h0,
    DDRSG_CMD_ZQCL = 4'h1,
    DDRSG_CMD_ZQCS = 4'h2,
    DDRSG_CMD_MPSM_ENTER = 4'h3,
    DDRSG_CMD_MPSM_EXIT = 4'h4,
    DDRSG_CMD_SRE = 4'h5,
    DDRSG_CMD_SRX = 4'h6,
    DDRSG_CMD_PDE = 4'h7,
    DDRSG_CMD_PDX = 4'h8,
    DDRSG_CMD_OTHER = 4'h9,
    DDRSG_CMD_MRS_FAST = 4'hA,
    DDRSG_CMD_DLL = 4'hB
  } ddrsg_cmd_type;
  typedef enum logic [2:0] {
    DDRSG_ST_RESET = 3'b000,
    DDRSG_ST_IDLE = 3'b001,
    DDRSG_ST_BUSY = 3'b010,
    DDRSG_ST_SR = 3'b011,
    DDRSG_ST_MPSM = 3'b100,
    DDRSG_ST_PD = 3'b101
  } ddrsg_state_type;
endpackage

// *** rtl/ddrsg_cnt_if.sv ***
// Purpose: Load and status signals of one down counter.
// Assumes: Single clock domain.
// Notes: The guard owns load; the counter reports done.
`timescale 1ns/1ps
`include "ddrsg_consts.svh"
interface ddrsg_cnt_if;
  logic load;
  logic [`DDRSG_CNT_W-1:0] value;
  logic done;
  modport owner (output load, output value, input done);
  modport counter (input load, input value, output done);
endinterface

// *** rtl/ddrsg_down_cnt.sv ***
// Purpose: Down counter that flags when a loaded wait has elapsed.
// Assumes: Load value is the number of cycles to wait.
// Notes: Done is high once the count reaches zero.
`timescale 1ns/1ps
`include "ddrsg_consts.svh"
module ddrsg_down_cnt
  import ddrsg_pkg::*;
(
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Counter control.
  ddrsg_cnt_if.counter cnt
);
  logic [`DDRSG_CNT_W-1:0] count;
  logic [`DDRSG_CNT_W-1:0] next_count;

  always_comb begin
    next_count = count;
    if (cnt.load) begin
      next_count = cnt.value;
    end else if (count != '0) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign cnt.done = (count == '0);
endmodule

// *** rtl/ddrsg_guard.sv ***
// Purpose: Controller-side guard spacing DDR4 low-power and ZQ commands.
// Assumes: 200 MHz controller clock; DRAM time figures given as parameters.
// Notes: Requests are held by the user until cmd_ready_o is high.
`timescale 1ns/1ps
`include "ddrsg_consts.svh"
// Functional notes
// - After reset allow 1024 cycles of initial ZQ before any command.
// - Long ZQ calibration blocks commands for 512 cycles.
// - Short ZQ calibration blocks commands for 128 cycles.
// - No commands during tMOD plus tCPDED after power saving mode entry.
// - Keep clock valid for tMOD plus tCPDED after power saving entry.
// - Restore clock tCKSRX before leaving power saving mode.
// - After power saving exit wait tXMP plus tXSDLL for DLL commands.
// - After reset CKE high wait max(5 cycles, tRFC+10ns) before commands.
// - After self-refresh exit wait tRFC+10ns for non-DLL commands.
// - With abort in use, non-DLL commands after tRFC4+10ns.
// - ZQ and fast MRS after self-refresh exit after tRFC4+10ns.
// - Commands needing DLL wait tDLLK after self-refresh exit.
// - CKE low in self refresh at least tCKE plus one cycle.
// - With parity, CKE low extends by parity latency too.
// - Keep clock valid max(5 cycles, 10ns) after SR or PD entry.
// - Command path disable delay is at least 4 cycles.
// - CKE pulse width is max(3 cycles, 5ns).
// - Clock valid max(5 cycles, 10ns) before SR, PD or reset exit.
module ddrsg_guard
  import ddrsg_pkg::*;
#(
  parameter int TMOD_CK = 24,
  parameter int TRFC_PS = 350000,
  parameter int TRFC4_PS = 160000,
  parameter int TXMP_CK = 64,
  parameter int TDLLK_CK = 768,
  parameter int PL_CK = 4
)(
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Command request from the scheduler.
  input wire logic cmd_valid_i,
  input wire ddrsg_cmd_type cmd_i,
  output logic cmd_ready_o,
  // Options.
  input wire logic sr_abort_i,
  input wire logic parity_en_i,
  // DRAM control pins.
  output logic cke_o,
  output logic ck_en_o,
  output logic cmd_fire_o,
  output ddrsg_cmd_type cmd_o,
  // Status.
  output ddrsg_state_type state_o
);
  // ********************************
  // Derived cycle counts.
  // ********************************
  function automatic int ps2ck(input int ps);
    return (ps + `DDRSG_CLK_PS - 1) / `DDRSG_CLK_PS;
  endfunction
  function automatic int maxi(input int a, input int b);
    return (a > b) ? a : b;
  endfunction
  function automatic logic [`DDRSG_CNT_W-1:0] w(input int v);
    return v[`DDRSG_CNT_W-1:0];
  endfunction

  localparam int MPED_CK = TMOD_CK + `DDRSG_CPDED_NCK;
  localparam int XPR_CK = maxi(`DDRSG_XPR_NCK,
    ps2ck(TRFC_PS + `DDRSG_RFC_EXTRA_PS));
  localparam int XS_CK = ps2ck(TRFC_PS + `DDRSG_RFC_EXTRA_PS);
  localparam int XSF_CK = ps2ck(TRFC4_PS + `DDRSG_RFC_EXTRA_PS);
  localparam int CKE_CK = maxi(`DDRSG_CKE_NCK,
    ps2ck(`DDRSG_CKE_PS));
  localparam int CKESR_CK = CKE_CK + `DDRSG_CKESR_EXTRA_NCK;
  localparam int CKSRE_CK = maxi(`DDRSG_CKSRE_NCK,
    ps2ck(`DDRSG_CKSRE_PS));
  localparam int CKSRX_CK = maxi(`DDRSG_CKSRX_NCK,
    ps2ck(`DDRSG_CKSRX_PS));
  localparam int XMPDLL_CK = TXMP_CK + TDLLK_CK;

  initial begin
    if (XPR_CK + `DDRSG_ZQINIT_NCK >= (1 << `DDRSG_CNT_W) ||
        XMPDLL_CK >= (1 << `DDRSG_CNT_W) || PL_CK < 0 ||
        TMOD_CK < 1) begin
      $error("ddrsg_guard: timing parameters exceed counter width");
    end
  end

  // ********************************
  // Counters.
  // ********************************
  ddrsg_cnt_if gen_if ();
  ddrsg_cnt_if dll_if ();
  ddrsg_cnt_if fast_if ();
  ddrsg_cnt_if clk_if ();

  ddrsg_down_cnt u_gen (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .cnt(gen_if));
  ddrsg_down_cnt u_dll (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .cnt(dll_if));
  ddrsg_down_cnt u_fast (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .cnt(fast_if));
  ddrsg_down_cnt u_clk (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .cnt(clk_if));

  // ********************************
  // Command acceptance.
  // ********************************
  ddrsg_state_type state;
  ddrsg_state_type next_state;
  logic cke;
  logic next_cke;
  logic ck_en;
  logic next_ck_en;
  logic fire;
  logic next_fire;
  ddrsg_cmd_type cmd_q;
  ddrsg_cmd_type next_cmd_q;
  logic ok;
  logic take;

  // Exit commands need the clock back early, so the clock counter also
  // gates them; this trades a few cycles of latency for simplicity.
  always_comb begin
    ok = 1'b0;
    case (state)
      DDRSG_ST_IDLE: begin
        case (cmd_i)
          DDRSG_CMD_ZQCL, DDRSG_CMD_ZQCS, DDRSG_CMD_MRS_FAST: begin
            ok = gen_if.done || fast_if.done;
          end
          DDRSG_CMD_DLL: begin
            ok = gen_if.done && dll_if.done;
          end
          default: begin
            ok = gen_if.done || (sr_abort_i && fast_if.done);
          end
        endcase
      end
      DDRSG_ST_SR, DDRSG_ST_MPSM, DDRSG_ST_PD: begin
        ok = gen_if.done && clk_if.done && ck_en;
        if (state == DDRSG_ST_SR) begin
          ok = ok && (cmd_i == DDRSG_CMD_SRX);
        end else if (state == DDRSG_ST_MPSM) begin
          ok = ok && (cmd_i == DDRSG_CMD_MPSM_EXIT);
        end else begin
          ok = ok && (cmd_i == DDRSG_CMD_PDX);
        end
      end
      default: begin
        ok = 1'b0;
      end
    endcase
  end

  assign cmd_ready_o = ok;
  assign take = cmd_valid_i && ok;

  always_comb begin
    next_state = state;
    next_cke = cke;
    next_ck_en = ck_en;
    next_fire = take;
    next_cmd_q = take ? cmd_i : DDRSG_CMD_NOP;
    gen_if.load = 1'b0;
    gen_if.value = '0;
    dll_if.load = 1'b0;
    dll_if.value = '0;
    fast_if.load = 1'b0;
    fast_if.value = '0;
    clk_if.load = 1'b0;
    clk_if.value = '0;
    case (state)
      DDRSG_ST_RESET: begin
        // The clock runs a full valid span before CKE may rise.
        next_ck_en = 1'b1;
        if (!ck_en) begin
          clk_if.load = 1'b1;
          clk_if.value = w(CKSRX_CK);
        end else if (clk_if.done) begin
          next_cke = 1'b1;
          next_state = DDRSG_ST_BUSY;
          gen_if.load = 1'b1;
          gen_if.value = w(XPR_CK + `DDRSG_ZQINIT_NCK);
        end
      end
      DDRSG_ST_BUSY: begin
        if (gen_if.done) begin
          next_state = DDRSG_ST_IDLE;
        end
      end
      DDRSG_ST_IDLE: begin
        if (take) begin
          case (cmd_i)
            DDRSG_CMD_ZQCL: begin
              gen_if.load = 1'b1;
              gen_if.value = w(`DDRSG_ZQOPER_NCK);
              fast_if.load = 1'b1;
              fast_if.value = w(`DDRSG_ZQOPER_NCK);
            end
            DDRSG_CMD_ZQCS: begin
              gen_if.load = 1'b1;
              gen_if.value = w(`DDRSG_ZQCS_NCK);
              fast_if.load = 1'b1;
              fast_if.value = w(`DDRSG_ZQCS_NCK);
            end
            DDRSG_CMD_MPSM_ENTER: begin
              next_state = DDRSG_ST_MPSM;
              gen_if.load = 1'b1;
              gen_if.value = w(MPED_CK);
              clk_if.load = 1'b1;
              clk_if.value = w(MPED_CK);
            end
            DDRSG_CMD_SRE, DDRSG_CMD_PDE: begin
              next_state = (cmd_i == DDRSG_CMD_SRE) ? DDRSG_ST_SR
                                                    : DDRSG_ST_PD;
              next_cke = 1'b0;
              gen_if.load = 1'b1;
              gen_if.value = parity_en_i ? w(CKESR_CK + PL_CK)
                                         : w(CKESR_CK);
              clk_if.load = 1'b1;
              clk_if.value = parity_en_i ? w(CKSRE_CK + PL_CK)
                                         : w(CKSRE_CK);
            end
            default: begin
            end
          endcase
        end
      end
      DDRSG_ST_SR, DDRSG_ST_MPSM, DDRSG_ST_PD: begin
        if (take) begin
          next_state = DDRSG_ST_IDLE;
          next_cke = 1'b1;
          gen_if.load = 1'b1;
          gen_if.value = (state == DDRSG_ST_SR) ? w(XS_CK)
                                                : w(TXMP_CK);
          fast_if.load = 1'b1;
          fast_if.value = (state == DDRSG_ST_SR) ? w(XSF_CK)
                                                : w(TXMP_CK);
          dll_if.load = 1'b1;
          dll_if.value = (state == DDRSG_ST_SR) ? w(TDLLK_CK)
                                                : w(XMPDLL_CK);
        end else if (clk_if.done && ck_en && !cmd_valid_i) begin
          // Clock stops only when idle; a pending exit restarts it.
          next_ck_en = 1'b0;
        end else if (cmd_valid_i && !ck_en) begin
          next_ck_en = 1'b1;
          clk_if.load = 1'b1;
          clk_if.value = w(CKSRX_CK);
        end
      end
      default: begin
        next_state = DDRSG_ST_RESET;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      state <= DDRSG_ST_RESET;
      cke <= 1'b0;
      ck_en <= 1'b0;
      fire <= 1'b0;
      cmd_q <= DDRSG_CMD_NOP;
    end else begin
      state <= next_state;
      cke <= next_cke;
      ck_en <= next_ck_en;
      fire <= next_fire;
      cmd_q <= next_cmd_q;
    end
  end

  assign cke_o = cke;
  assign ck_en_o = ck_en;
  assign cmd_fire_o = fire;
  assign cmd_o = cmd_q;
  assign state_o = state;
endmodule

// *** verification/ddrsg_guard_monitor.sv ***
// Purpose: Port assertions for the DDR4 spacing guard.
// Assumes: 5 ns clock; gaps count cycles between fire pulses.
// Notes: Minimums only, so a slower guard still passes.
`timescale 1ns/1ps
module ddrsg_guard_monitor
  import ddrsg_pkg::*;
#(
  parameter int TMOD_CK = 24, TRFC_PS = 350000, TRFC4_PS = 160000,
  parameter int TXMP_CK = 64, TDLLK_CK = 768, PL_CK = 4
)(
  // Guard ports.
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic cmd_valid_i,
  input wire ddrsg_cmd_type cmd_i,
  input wire logic cmd_ready_o,
  input wire logic sr_abort_i,
  input wire logic parity_en_i,
  input wire logic cke_o,
  input wire logic ck_en_o,
  input wire logic cmd_fire_o,
  input wire ddrsg_cmd_type cmd_o,
  input wire ddrsg_state_type state_o
);
  // ****************
  // Checks
  // ****************
  localparam int XS = (TRFC_PS + 14999) / 5000;
  localparam int XSF = (TRFC4_PS + 14999) / 5000;
  localparam int XPR = XS > 5 ? XS : 5;
  logic [15:0] gap;
  logic [15:0] ckon;
  logic [15:0] srx;
  logic first;
  ddrsg_cmd_type last;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // Counts saturate, so a long idle spell cannot wrap to a short gap.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      gap <= 16'h0;
      ckon <= 16'h0;
      srx <= 16'hFFFF;
      first <= 1'b1;
      last <= DDRSG_CMD_NOP;
    end else begin
      gap <= cmd_fire_o ? 16'h1 : gap + {15'h0, gap != 16'hFFFF};
      ckon <= ck_en_o ? ckon + {15'h0, ckon != 16'hFFFF} : 16'h0;
      srx <= (cmd_fire_o && cmd_o == DDRSG_CMD_SRX) ? 16'h1
        : srx + {15'h0, srx != 16'hFFFF};
      first <= first & ~cmd_fire_o;
      last <= cmd_fire_o ? cmd_o : last;
    end
  end
  AST_RST_WAIT: assert property (
    cmd_fire_o && first |-> gap >= 1024 + XPR) else $error("early start");
  AST_ZQCL_GAP: assert property (
    cmd_fire_o && last == DDRSG_CMD_ZQCL |-> gap >= 512) else $error("zq");
  AST_ZQCS_GAP: assert property (
    cmd_fire_o && last == DDRSG_CMD_ZQCS |-> gap >= 128) else $error("zq");
  AST_MPSM_GAP: assert property (
    cmd_fire_o && last == DDRSG_CMD_MPSM_ENTER |-> gap >= TMOD_CK + 4)
    else $error("mpsm entry gap");
  AST_MPSM_DLL: assert property (
    cmd_fire_o && last == DDRSG_CMD_MPSM_EXIT && cmd_o == DDRSG_CMD_DLL
    |-> gap >= TXMP_CK + TDLLK_CK) else $error("mpsm exit gap");
  AST_SRX_GEN: assert property (
    cmd_fire_o && last == DDRSG_CMD_SRX && cmd_o == DDRSG_CMD_OTHER
    |-> gap >= (sr_abort_i ? XSF : XS)) else $error("srx gap");
  AST_SRX_DLL: assert property (
    cmd_fire_o && cmd_o == DDRSG_CMD_DLL
    |-> srx >= TDLLK_CK) else $error("srx dll gap");
  AST_CKE_LOW: assert property (
    cmd_fire_o && last == DDRSG_CMD_SRE
    |-> gap >= 4 + (parity_en_i ? PL_CK : 0)) else $error("cke low");
  AST_CK_AFTER: assert property (
    $fell(cke_o) |-> ck_en_o [*5]) else $error("clock stopped early");
  AST_CK_BEFORE: assert property (
    $rose(cke_o) |-> ckon >= 5)
    else $error("clock late");
  cover property (cmd_fire_o && cmd_o == DDRSG_CMD_SRX);
  cover property (cmd_fire_o && cmd_o == DDRSG_CMD_MPSM_EXIT);
  cover property (cmd_valid_i && !cmd_ready_o && cmd_i == DDRSG_CMD_ZQCS);
endmodule
bind ddrsg_guard ddrsg_guard_monitor #(.TMOD_CK(TMOD_CK), .TRFC_PS(TRFC_PS),
  .TRFC4_PS(TRFC4_PS), .TXMP_CK(TXMP_CK), .TDLLK_CK(TDLLK_CK), .PL_CK(PL_CK))
  u_mon (.mclk_i, .rst_n_i, .cmd_valid_i, .cmd_i, .cmd_ready_o, .sr_abort_i,
  .parity_en_i, .cke_o, .ck_en_o, .cmd_fire_o, .cmd_o, .state_o);

// *** verification/ddrsg_dram_model.sv ***
// Purpose: DRAM model that counts commands it would lose.
// Assumes: Commands arrive as one-cycle fire pulses.
// Notes: Only the command-path rules are modelled.
`timescale 1ns/1ps
module ddrsg_dram_model
  import ddrsg_pkg::*;
#(
  parameter int TMOD_CK = 24
)(
  // Pins from the guard.
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic ck_en_i,
  input wire logic fire_i,
  input wire ddrsg_cmd_type cmd_i,
  // Lost command count.
  output logic [7:0] err_o
);
  // ****************
  // Command path
  // ****************
  int dis;
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      dis <= 0;
      err_o <= 8'h0;
    end else begin
      if (fire_i && cmd_i == DDRSG_CMD_MPSM_ENTER) begin
        dis <= TMOD_CK + 3;
      end else if (dis > 0) begin
        dis <= dis - 1;
      end
      // Without a clock the path would never finish shutting down.
      if ((fire_i || !ck_en_i) && dis > 0) begin
        err_o <= err_o + 8'h1;
      end
    end
  end
endmodule

// *** verification/ddrsg_guard_tb.sv ***
// Purpose: Self-checking bench for the DDR4 spacing guard.
// Assumes: Short refresh and lock times keep the run brief.
// Notes: Spacing is measured between fire pulses.
`timescale 1ns/1ps
module ddrsg_guard_tb;
  import ddrsg_pkg::*;
  // ****************
  // Bench
  // ****************
  localparam int XS = 4;
  localparam int XSF = 3;
  localparam int DLLK = 8;
  localparam int XMP = 4;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic cmd_valid_i = 1'b0;
  logic sr_abort_i = 1'b0;
  logic parity_en_i = 1'b0;
  ddrsg_cmd_type cmd_i = DDRSG_CMD_NOP;
  logic cmd_ready_o, cke_o, ck_en_o, cmd_fire_o;
  ddrsg_cmd_type cmd_o;
  ddrsg_state_type state_o;
  logic [7:0] dram_err;
  int fails = 0, compares = 0, cyc = 0, last = 0, g;
  initial forever #2.5 mclk_i = ~mclk_i;
  always @(posedge mclk_i) cyc <= cyc + 1;
  ddrsg_guard #(.TRFC_PS(10000), .TRFC4_PS(5000), .TXMP_CK(XMP),
    .TDLLK_CK(DLLK)) DUT (.mclk_i, .rst_n_i, .cmd_valid_i, .cmd_i,
    .cmd_ready_o, .sr_abort_i, .parity_en_i, .cke_o, .ck_en_o, .cmd_fire_o,
    .cmd_o, .state_o);
  ddrsg_dram_model MODEL (.mclk_i, .rst_n_i, .ck_en_i(ck_en_o),
    .fire_i(cmd_fire_o), .cmd_i(cmd_o), .err_o(dram_err));
  task automatic end_of_test();
    if (fails == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input bit atleast);
    compares++;
    if (atleast ? ((got >= exp) !== 1'b1) : (got !== exp)) begin
      fails++;
      $display("Error at %0t: got %0h, expected %0h", $time, got, exp);
    end
  endtask
  task automatic tick();
    @(posedge mclk_i);
    #1;
  endtask
  // Holds the request until taken, then checks the fire pulse.
  task automatic issue(input ddrsg_cmd_type c, output int gap);
    int n;
    n = 0;
    cmd_i = c;
    cmd_valid_i = 1'b1;
    #1;
    while (cmd_ready_o !== 1'b1) begin
      tick();
      n++;
      if (n > 3000) begin
        fails++;
        end_of_test();
      end
    end
    tick();
    chk(32'(cmd_fire_o), 32'h1, 1'b0);
    chk(32'(cmd_o), 32'(c), 1'b0);
    gap = cyc - last;
    last = cyc;
  endtask
  task automatic t_reset();
    repeat (8) @(posedge mclk_i);
    #1;
    rst_n_i = 1'b1;
    last = cyc;
    tick();
    chk(32'(ck_en_o), 32'h1, 1'b0);
    chk(32'(cke_o), 32'h0, 1'b0);
    issue(DDRSG_CMD_OTHER, g);
    chk(g, 1029, 1'b1);
  endtask
  task automatic t_zq();
    issue(DDRSG_CMD_ZQCL, g);
    issue(DDRSG_CMD_ZQCS, g);
    chk(g, 512, 1'b1);
    issue(DDRSG_CMD_MRS_FAST, g);
    chk(g, 128, 1'b1);
  endtask
  task automatic t_mpsm();
    issue(DDRSG_CMD_MPSM_ENTER, g);
    issue(DDRSG_CMD_MPSM_EXIT, g);
    chk(g, 28, 1'b1);
    issue(DDRSG_CMD_DLL, g);
    chk(g, XMP + DLLK, 1'b1);
    issue(DDRSG_CMD_PDE, g);
    issue(DDRSG_CMD_PDX, g);
    chk(g, 4, 1'b1);
  endtask
  task automatic t_sr(input logic par, input logic ab,
                      input ddrsg_cmd_type c, input int n);
    int k;
    int s;
    parity_en_i = par;
    sr_abort_i = ab;
    issue(DDRSG_CMD_SRE, g);
    cmd_valid_i = 1'b0;
    k = 1;
    chk(32'(cke_o), 32'h0, 1'b0);
    chk(32'(state_o), 32'(DDRSG_ST_SR), 1'b0);
    while (ck_en_o !== 1'b0 && k < 99) begin
      tick();
      k++;
    end
    chk(32'(ck_en_o), 32'h0, 1'b0);
    chk(k, par ? 9 : 5, 1'b1);
    tick();
    issue(DDRSG_CMD_SRX, g);
    chk(g, par ? 8 : 4, 1'b1);
    chk(32'(cke_o), 32'h1, 1'b0);
    chk(32'(state_o), 32'(DDRSG_ST_IDLE), 1'b0);
    s = last;
    issue(c, g);
    chk(g, n, 1'b1);
    issue(DDRSG_CMD_DLL, g);
    chk(cyc - s, DLLK, 1'b1);
  endtask
  initial begin
    t_reset();
    t_zq();
    t_mpsm();
    t_sr(1'b1, 1'b0, DDRSG_CMD_OTHER, XS);
    t_sr(1'b0, 1'b1, DDRSG_CMD_OTHER, XSF);
    t_sr(1'b0, 1'b0, DDRSG_CMD_ZQCS, XSF);
    chk(32'(dram_err), 32'h0, 1'b0);
    end_of_test();
  end
endmodule
